// [pkg/ecd_pkg.sv]
// Purpose: Constants and types for the eight-channel DMA register block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Channel x registers sit at ECD_CH_STRIDE * x plus a per-register offset
`default_nettype none
package ecd_pkg;
   localparam int ECD_NCH = 8;
   localparam logic [11:0] ECD_CH_STRIDE = 12'h020;
   localparam logic [4:0] ECD_OFF_CTRL = 5'h00;
   localparam logic [4:0] ECD_OFF_REQ = 5'h04;
   localparam logic [4:0] ECD_OFF_STA = 5'h08;
   localparam logic [4:0] ECD_OFF_STB = 5'h0c;
   localparam logic [4:0] ECD_OFF_PAD = 5'h10;
   localparam logic [4:0] ECD_OFF_CNT = 5'h14;
   localparam logic [11:0] ECD_OFF_COLL = 12'h100;
   localparam logic [15:0] ECD_RESET_VAL = 16'h0000;
   // Control and request field positions, register masks
   localparam int ECD_B_ON = 15;
   localparam int ECD_B_SIZE = 14;
   localparam int ECD_B_DIR = 13;
   localparam int ECD_B_HALF = 12;
   localparam int ECD_B_NULL = 11;
   localparam int ECD_B_AM = 4;
   localparam int ECD_B_FORCE = 15;
   localparam logic [15:0] ECD_CTRL_MASK = 16'hf833;
   localparam logic [15:0] ECD_REQ_MASK = 16'h007f;
   localparam logic [15:0] ECD_CNT_MASK = 16'h03ff;
   // Addressing modes
   localparam logic [1:0] ECD_AM_POSTINC = 2'b00;
   localparam logic [1:0] ECD_AM_NOINC = 2'b01;
   localparam logic [1:0] ECD_AM_PERIND = 2'b10;
   // Operating modes: bit 0 one-shot, bit 1 ping-pong
   localparam int ECD_M_ONESHOT = 0;
   localparam int ECD_M_PINGPONG = 1;
   typedef enum logic [2:0] {
      ECD_IDLE = 3'b001,
      ECD_READ = 3'b010,
      ECD_WRITE = 3'b100
   } ecd_state_type;
endpackage
`default_nettype wire

// [src/ecd_dma.sv]
// Purpose: Eight-channel DMA register file and transfer engine (APB slave)
// Assumes: Single-cycle DMA RAM and peripheral ports; requests and collision inputs pass through two-flop synchronisers
// Notes: One transfer is serviced at a time, lowest channel first
// Functional notes
// - Eight channels, 16-bit registers, 10-bit count
// - Shared status register covers all channels
// - Bit 15 enables, bit 14 byte size
// - Bit 13 picks RAM-to-peripheral direction
// - Bit 12 half-block interrupt select
// - Bits 1-0 one-shot / ping-pong mode
// - Force bit starts one manual transfer
// - Force bit cleared only by hardware
// - Bits 6-0 pick request line 0-127
// - Primary RAM start offset
// - Secondary offset, used by ping-pong
// - Peripheral address register
// - Count plus one transfers, upper zero
// - Status 7-0 RAM collisions, clear-only
// - Per-channel interrupt on block or half
// - One-shot stops; continuous reloads; ping-pong alternates
`default_nettype none
module ecd_dma
   import ecd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [127:0] periph_req,
   input wire logic [15:0] periph_ram_addr,
   input wire logic [7:0] periph_coll,
   input wire logic [7:0] ram_coll,
   output logic ram_en,
   output logic ram_we,
   output logic ram_byte,
   output logic [15:0] ram_addr,
   output logic [15:0] ram_wdata,
   input wire logic [15:0] ram_rdata,
   output logic per_en,
   output logic per_we,
   output logic [15:0] per_addr,
   output logic [15:0] per_wdata,
   input wire logic [15:0] per_rdata,
   output logic [7:0] chan_irq
);
   logic [15:0] ctrl_r [ECD_NCH];
   logic [15:0] req_r [ECD_NCH];
   logic [15:0] sta_r [ECD_NCH];
   logic [15:0] stb_r [ECD_NCH];
   logic [15:0] pad_r [ECD_NCH];
   logic [9:0] cnt_r [ECD_NCH];
   logic [9:0] done_r [ECD_NCH];
   logic [15:0] ofs_r [ECD_NCH];
   logic [7:0] pp_r;
   logic [7:0] pend_r;
   logic [7:0] stop_r;
   logic [15:0] coll_r;
   logic [127:0] req_s1_r, req_s2_r;
   logic [7:0] pc_s1_r, pc_s2_r, rc_s1_r, rc_s2_r;
   ecd_state_type state_r;
   logic [2:0] cur_r;

   // APB decode; zero-wait answer
   wire wr_acc = psel & penable & pwrite;
   wire [2:0] a_ch = paddr[7:5];
   wire a_chan = (paddr[11:8] == 4'h0) & (paddr[1:0] == 2'b00);
   wire [4:0] a_off = paddr[4:0];
   wire a_coll = (paddr == ECD_OFF_COLL);
   wire a_known = a_coll | (a_chan & (a_off <= ECD_OFF_CNT));
   wire [15:0] wd = pwdata[15:0];

   // Read value per address
   function automatic logic [15:0] rd_sel(input logic [4:0] off, input logic [2:0] ch,
                                          input logic cs);
      logic [15:0] v;
      v = 16'h0000;
      if (cs) v = coll_r;
      else case (off)
         ECD_OFF_CTRL: v = ctrl_r[ch];
         ECD_OFF_REQ: v = req_r[ch];
         ECD_OFF_STA: v = sta_r[ch];
         ECD_OFF_STB: v = stb_r[ch];
         ECD_OFF_PAD: v = pad_r[ch];
         ECD_OFF_CNT: v = {6'h00, cnt_r[ch]};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // Channel in service ignores its own trigger until its write is issued
   wire busy = (state_r != ECD_IDLE);
   // Software sets the force bit of the channel in its write cycle
   wire force_wr = wr_acc & pready & a_chan & (a_off == ECD_OFF_REQ) & (a_ch == cur_r) &
                   wd[ECD_B_FORCE];

   // Request sync and pending detection
   logic [7:0] trig;
   always_comb begin
      for (int i = 0; i < ECD_NCH; i++) begin
         trig[i] = ctrl_r[i][ECD_B_ON] & ~stop_r[i] &
                   ~(busy & (cur_r == 3'(i))) &
                   (req_r[i][ECD_B_FORCE] | req_s2_r[req_r[i][6:0]]);
      end
   end

   // Lowest pending channel wins
   logic [2:0] pick;
   logic any_pend;
   always_comb begin
      pick = 3'd0;
      any_pend = 1'b0;
      for (int i = ECD_NCH - 1; i >= 0; i--) begin
         if (pend_r[i]) begin
            pick = 3'(i);
            any_pend = 1'b1;
         end
      end
   end

   wire [15:0] cc = ctrl_r[cur_r];
   wire to_per = cc[ECD_B_DIR];
   wire [1:0] am = cc[ECD_B_AM +: 2];
   wire [15:0] start_ofs = (ctrl_r[pick][ECD_M_PINGPONG] & pp_r[pick]) ? stb_r[pick]
                                                                         : sta_r[pick];
   wire [15:0] cur_ram = (am == ECD_AM_PERIND) ? (ofs_r[cur_r] + periph_ram_addr)
                                               : ofs_r[cur_r];
   wire last = (done_r[cur_r] == cnt_r[cur_r]);
   wire half = (done_r[cur_r] == {1'b0, cnt_r[cur_r][9:1]});
   wire [15:0] step = cc[ECD_B_SIZE] ? 16'h0001 : 16'h0002;

   // APB outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~a_known;
         prdata <= {16'h0000, rd_sel(a_off, a_ch, a_coll)};
      end
   end

   // Synchronisers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         req_s1_r <= '0;
         req_s2_r <= '0;
         pc_s1_r <= 8'h00;
         pc_s2_r <= 8'h00;
         rc_s1_r <= 8'h00;
         rc_s2_r <= 8'h00;
      end else begin
         req_s1_r <= periph_req;
         req_s2_r <= req_s1_r;
         pc_s1_r <= periph_coll;
         pc_s2_r <= pc_s1_r;
         rc_s1_r <= ram_coll;
         rc_s2_r <= rc_s1_r;
      end
   end

   // Collision flags: set wins over software clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) coll_r <= ECD_RESET_VAL;
      else if (wr_acc & pready & a_coll)
         coll_r <= (coll_r & wd) | {pc_s2_r, rc_s2_r};
      else coll_r <= coll_r | {pc_s2_r, rc_s2_r};
   end

   // Register file and engine state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ECD_NCH; i++) begin
            ctrl_r[i] <= ECD_RESET_VAL;
            req_r[i] <= ECD_RESET_VAL;
            sta_r[i] <= ECD_RESET_VAL;
            stb_r[i] <= ECD_RESET_VAL;
            pad_r[i] <= ECD_RESET_VAL;
            cnt_r[i] <= 10'h000;
            done_r[i] <= 10'h000;
            ofs_r[i] <= ECD_RESET_VAL;
         end
         pp_r <= 8'h00;
         pend_r <= 8'h00;
         stop_r <= 8'h00;
         state_r <= ECD_IDLE;
         cur_r <= 3'd0;
         ram_en <= 1'b0;
         ram_we <= 1'b0;
         ram_byte <= 1'b0;
         ram_addr <= 16'h0000;
         ram_wdata <= 16'h0000;
         per_en <= 1'b0;
         per_we <= 1'b0;
         per_addr <= 16'h0000;
         per_wdata <= 16'h0000;
         chan_irq <= 8'h00;
      end else begin
         pend_r <= pend_r | trig;
         chan_irq <= 8'h00;
         ram_en <= 1'b0;
         ram_we <= 1'b0;
         per_en <= 1'b0;
         per_we <= 1'b0;
         if (wr_acc & pready & a_chan) begin
            case (a_off)
               ECD_OFF_CTRL: begin
                  ctrl_r[a_ch] <= wd & ECD_CTRL_MASK;
                  stop_r[a_ch] <= 1'b0;
                  pp_r[a_ch] <= 1'b0;
                  done_r[a_ch] <= 10'h000;
                  ofs_r[a_ch] <= sta_r[a_ch];
               end
               ECD_OFF_REQ: // Force only settable by software
                  req_r[a_ch] <= (wd & ECD_REQ_MASK) |
                                 {wd[ECD_B_FORCE] | req_r[a_ch][ECD_B_FORCE], 15'h0000};
               ECD_OFF_STA: sta_r[a_ch] <= wd;
               ECD_OFF_STB: stb_r[a_ch] <= wd;
               ECD_OFF_PAD: pad_r[a_ch] <= wd;
               ECD_OFF_CNT: cnt_r[a_ch] <= wd[9:0];
               default: ;
            endcase
         end
         case (state_r)
            ECD_IDLE: begin
               if (any_pend) begin
                  cur_r <= pick;
                  pend_r[pick] <= 1'b0;
                  if (done_r[pick] == 10'h000) ofs_r[pick] <= start_ofs;
                  state_r <= ECD_READ;
               end
            end
            ECD_READ: begin
               if (to_per) begin
                  ram_en <= 1'b1;
                  ram_byte <= cc[ECD_B_SIZE];
                  ram_addr <= cur_ram;
               end else begin
                  per_en <= 1'b1;
                  per_addr <= pad_r[cur_r];
               end
               state_r <= ECD_WRITE;
            end
            ECD_WRITE: begin
               if (to_per) begin
                  per_en <= 1'b1;
                  per_we <= 1'b1;
                  per_addr <= pad_r[cur_r];
                  per_wdata <= ram_rdata;
               end else begin
                  ram_en <= 1'b1;
                  ram_we <= 1'b1;
                  ram_byte <= cc[ECD_B_SIZE];
                  ram_addr <= cur_ram;
                  ram_wdata <= per_rdata;
                  if (cc[ECD_B_NULL]) begin
                     per_en <= 1'b1;
                     per_we <= 1'b1;
                     per_addr <= pad_r[cur_r];
                     per_wdata <= 16'h0000;
                  end
               end
               if (am == ECD_AM_POSTINC) ofs_r[cur_r] <= ofs_r[cur_r] + step;
               // A force set by software in this cycle survives
               if (~force_wr) req_r[cur_r][ECD_B_FORCE] <= 1'b0;
               if (cc[ECD_B_HALF] & half) chan_irq[cur_r] <= 1'b1;
               if (last) begin
                  done_r[cur_r] <= 10'h000;
                  if (~cc[ECD_B_HALF]) chan_irq[cur_r] <= 1'b1;
                  if (cc[ECD_M_PINGPONG]) pp_r[cur_r] <= ~pp_r[cur_r];
                  if (cc[ECD_M_ONESHOT] & (~cc[ECD_M_PINGPONG] | pp_r[cur_r]))
                     stop_r[cur_r] <= 1'b1;
               end else begin
                  done_r[cur_r] <= done_r[cur_r] + 10'h001;
               end
               state_r <= ECD_IDLE;
            end
            default: state_r <= ECD_IDLE;
         endcase
      end
   end

   // Checks
   a_apb_zero_wait: assert property (@(posedge ref_clk) disable iff (rst)
      psel & ~penable |=> pready) else $error("apb not ready in access");
   a_force_clear: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE && !force_wr |=> ~req_r[$past(cur_r)][ECD_B_FORCE])
      else $error("force not cleared");
   a_coll_sticky: assert property (@(posedge ref_clk) disable iff (rst)
      (coll_r[15:8] & $past(pc_s2_r)) == $past(pc_s2_r))
      else $error("peripheral collision lost");
   a_xcoll_sticky: assert property (@(posedge ref_clk) disable iff (rst)
      (coll_r[7:0] & $past(rc_s2_r)) == $past(rc_s2_r))
      else $error("ram collision lost");
   a_cnt_upper: assert property (@(posedge ref_clk) disable iff (rst)
      pready & a_chan & a_off == ECD_OFF_CNT |-> prdata[15:10] == 6'h00)
      else $error("count upper bits set");
   sequence s_xfer;
      state_r == ECD_READ ##1 state_r == ECD_WRITE;
   endsequence
   a_xfer_steps: assert property (@(posedge ref_clk) disable iff (rst)
      s_xfer |=> (per_we | ram_we) && state_r == ECD_IDLE) else $error("no write step");
   a_null_write: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE && ~to_per && cc[ECD_B_NULL] |=> per_we && per_wdata == 16'h0000)
      else $error("null write missing");
   a_off_on_idle: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_IDLE && !any_pend |=> !ram_en && !per_en) else $error("stray access");
   a_ctrl_mask: assert property (@(posedge ref_clk) disable iff (rst)
      (ctrl_r[0] & ~ECD_CTRL_MASK) == 16'h0000) else $error("reserved control bits set");

   // Forced transfer runs once, interrupts follow the block position
   a_force_once: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE |=> !pend_r[$past(cur_r)])
      else $error("forced transfer repeated");
   a_half_irq: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE && cc[ECD_B_HALF] && half |=> chan_irq[$past(cur_r)])
      else $error("half interrupt missing");
   a_block_irq: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE && !cc[ECD_B_HALF] && last |=> chan_irq[$past(cur_r)])
      else $error("block interrupt missing");
   // Read step never writes; one-shot ends; post-increment steps the offset
   a_read_only: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_READ |=> !ram_we && !per_we)
      else $error("write during read step");
   a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE && last && cc[ECD_M_ONESHOT] && !cc[ECD_M_PINGPONG]
      |=> stop_r[$past(cur_r)]) else $error("one-shot not stopped");
   a_post_inc: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ECD_WRITE && am == ECD_AM_POSTINC && !(wr_acc & pready & a_chan)
      |=> ofs_r[$past(cur_r)] == $past(ofs_r[cur_r] + step)) else $error("offset not stepped");
endmodule
`default_nettype wire

// [testbench/ecd_partner.sv]
// Purpose: Far-side model of peripheral registers and the dual-ported DMA RAM
// Assumes: Reads are combinational while the matching enable is high
// Notes: Released data lines show the inverse of the last value driven
`default_nettype none
module ecd_partner (
   input wire logic ref_clk,
   input wire logic ram_en,
   input wire logic ram_we,
   input wire logic [15:0] ram_addr,
   input wire logic [15:0] ram_wdata,
   output logic [15:0] ram_rdata,
   input wire logic per_en,
   input wire logic [15:0] per_addr,
   output logic [15:0] per_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:1023];
   logic [15:0] ram_last = 16'h0000;
   logic [15:0] per_last = 16'h0000;
   // Peripheral register image derived from its address; stale lines inverted
   assign per_rdata = per_en ? (per_addr ^ 16'h3c5a) : ~per_last;
   assign ram_rdata = ram_en ? mem[ram_addr[10:1]] : ~ram_last;
   // Word store for RAM writes, last read values kept for the idle pattern
   always @(posedge ref_clk) begin
      if (ram_en && ram_we) begin
         mem[ram_addr[10:1]] <= ram_wdata;
      end
      if (ram_en) begin
         ram_last <= ram_rdata;
      end
      if (per_en) begin
         per_last <= per_rdata;
      end
   end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the eight-channel DMA register block
// Assumes: APB master tasks, far-side model for peripheral and RAM
// Notes: Drivers queue expected results, a monitor pops and compares them
`default_nettype none
module tb_top
   import ecd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [127:0] periph_req = '0;
   logic [15:0] periph_ram_addr = 16'h0000;
   logic [7:0] periph_coll = 8'h00;
   logic [7:0] ram_coll = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, ram_en, ram_we, ram_byte, per_en, per_we;
   logic [15:0] ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
   logic [7:0] chan_irq;
   logic [32:0] apb_q[$];
   logic [32:0] ram_q[$];
   logic [31:0] per_q[$];
   int fail_count = 0;
   int checked = 0;
   ecd_dma dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_req(periph_req), .periph_ram_addr(periph_ram_addr),
      .periph_coll(periph_coll), .ram_coll(ram_coll), .ram_en(ram_en), .ram_we(ram_we),
      .ram_byte(ram_byte), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata), .per_en(per_en), .per_we(per_we), .per_addr(per_addr),
      .per_wdata(per_wdata), .per_rdata(per_rdata), .chan_irq(chan_irq));
   ecd_partner far (.ref_clk(ref_clk), .ram_en(ram_en), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
      .per_en(per_en), .per_addr(per_addr), .per_rdata(per_rdata));
   // Clock at 100 MHz
   always #5 ref_clk = ~ref_clk;
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Monitor: every read answer and every far-side write takes the oldest note
   always @(posedge ref_clk) begin : mon
      logic [32:0] e;
      if (psel && penable && pready && !pwrite) begin
         e = apb_q.size() != 0 ? apb_q.pop_front() : '1;
         chk(e[32] ? {pslverr, 32'h0} : {pslverr, prdata}, e);
      end
      if (ram_en && ram_we) begin
         e = ram_q.size() != 0 ? ram_q.pop_front() : '1;
         chk({ram_byte, ram_addr, ram_wdata}, e);
      end
      if (per_en && per_we) begin
         e = per_q.size() != 0 ? {1'b0, per_q.pop_front()} : '1;
         chk({1'b0, per_addr, per_wdata}, e);
      end
   end
   // APB transfer: setup, access, hold until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic err, input logic [15:0] v);
      apb_q.push_back({err, 16'h0, v});
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [11:0] ra(input int ch, input logic [4:0] off);
      return ECD_CH_STRIDE * 12'(ch) + {7'h0, off};
   endfunction
   // Control written last, after address and count, so no change while on
   task automatic setup(input int ch, input logic [15:0] primary_offset_field, stb, pad, cnt, ctrl);
      wr(ra(ch, ECD_OFF_STA), primary_offset_field);
      wr(ra(ch, ECD_OFF_STB), stb);
      wr(ra(ch, ECD_OFF_PAD), pad);
      wr(ra(ch, ECD_OFF_CNT), cnt);
      wr(ra(ch, ECD_OFF_CTRL), ctrl);
   endtask
   // Watch a fixed span for the channel interrupt
   task automatic watch(input int ch, input logic irq);
      logic seen;
      seen = 1'b0;
      repeat (12) @(posedge ref_clk) seen |= chan_irq[ch];
      chk({32'h0, seen}, {32'h0, irq});
   endtask
   task automatic kick(input int ch, input logic irq);
      wr(ra(ch, ECD_OFF_REQ), 16'h8000);
      watch(ch, irq);
      rd(ra(ch, ECD_OFF_REQ), 1'b0, 16'h0);
   endtask
   initial begin
      logic [15:0] v [6];
      int s;
      void'($urandom(32'h99dd));
      periph_ram_addr <= 16'($urandom());
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values of every register
      for (int c = 0; c < ECD_NCH; c++)
         for (int r = 0; r < 6; r++) rd(ra(c, 5'(4 * r)), 1'b0, 16'h0);
      rd(ECD_OFF_COLL, 1'b0, 16'h0);
      // Random fill per channel, unused bits read as zero
      for (int c = 0; c < ECD_NCH; c++) begin
         foreach (v[i]) v[i] = 16'($urandom());
         v[1][15] = 1'b0;
         for (int r = 5; r >= 0; r--) wr(ra(c, 5'(4 * r)), v[r]);
         rd(ra(c, ECD_OFF_CTRL), 1'b0, v[0] & ECD_CTRL_MASK);
         rd(ra(c, ECD_OFF_REQ), 1'b0, v[1] & ECD_REQ_MASK);
         rd(ra(c, ECD_OFF_STA), 1'b0, v[2]);
         rd(ra(c, ECD_OFF_STB), 1'b0, v[3]);
         rd(ra(c, ECD_OFF_PAD), 1'b0, v[4]);
         rd(ra(c, ECD_OFF_CNT), 1'b0, v[5] & ECD_CNT_MASK);
         wr(ra(c, ECD_OFF_CTRL), 16'h0);
      end
      // Unmapped places answer with an error
      wr(12'h0f8, 16'hffff);
      rd(12'h0f8, 1'b1, 16'h0);
      rd(12'h1f0, 1'b1, 16'h0);
      // Collision flags: set by events, cleared only by writing zero
      ram_coll <= 8'h08;
      periph_coll <= 8'h40;
      @(posedge ref_clk);
      ram_coll <= 8'h00;
      periph_coll <= 8'h00;
      repeat (4) @(posedge ref_clk);
      rd(ECD_OFF_COLL, 1'b0, 16'h4008);
      wr(ECD_OFF_COLL, 16'h4000);
      rd(ECD_OFF_COLL, 1'b0, 16'h4000);
      wr(ECD_OFF_COLL, 16'h0000);
      rd(ECD_OFF_COLL, 1'b0, 16'h0000);
      // Peripheral to RAM, word, post-increment, null writes, two transfers
      setup(2, 16'h0040, 16'h0000, 16'h0010, 16'h0001, 16'h8801);
      for (int k = 0; k < 2; k++) begin
         ram_q.push_back({1'b0, 16'(16'h0040 + 2 * k), 16'h3c4a});
         per_q.push_back({16'h0010, 16'h0000});
         kick(2, 1'(k));
      end
      // Byte size steps the RAM address by one
      setup(1, 16'h0081, 16'h0000, 16'h3c10, 16'h0001, 16'hc001);
      ram_q.push_back({1'b1, 16'h0081, 16'h004a});
      ram_q.push_back({1'b1, 16'h0082, 16'h004a});
      kick(1, 1'b0);
      kick(1, 1'b1);
      // RAM to peripheral, no increment
      setup(3, 16'h0040, 16'h0000, 16'h0200, 16'h0000, 16'ha011);
      per_q.push_back({16'h0200, 16'h3c4a});
      kick(3, 1'b1);
      // Continuous ping-pong alternates the two start offsets
      setup(4, 16'h0100, 16'h0180, 16'h0020, 16'h0000, 16'h8002);
      ram_q.push_back({1'b0, 16'h0100, 16'h3c7a});
      kick(4, 1'b1);
      ram_q.push_back({1'b0, 16'h0180, 16'h3c7a});
      kick(4, 1'b1);
      // Peripheral supplies part of the RAM address
      setup(6, 16'h0200, 16'h0000, 16'h0040, 16'h0000, 16'h8021);
      ram_q.push_back({1'b0, 16'(16'h0200 + periph_ram_addr), 16'h3c1a});
      kick(6, 1'b1);
      // Half-block interrupt on the first of two, no increment
      setup(7, 16'h0280, 16'h0000, 16'h0050, 16'h0001, 16'h9011);
      ram_q.push_back({1'b0, 16'h0280, 16'h3c0a});
      ram_q.push_back({1'b0, 16'h0280, 16'h3c0a});
      kick(7, 1'b1);
      kick(7, 1'b0);
      // Automatic start from a randomly selected request line
      s = $urandom_range(127, 1);
      setup(5, 16'h0300, 16'h0000, 16'h0030, 16'h0000, 16'h8001);
      wr(ra(5, ECD_OFF_REQ), 16'(s));
      ram_q.push_back({1'b0, 16'h0300, 16'h3c6a});
      periph_req[s] <= 1'b1;
      @(posedge ref_clk);
      periph_req <= '0;
      watch(5, 1'b1);
      repeat (5) @(posedge ref_clk);
      chk({1'b0, 32'(ram_q.size() + per_q.size() + apb_q.size())}, 33'h0);
      final_report();
   end
   // Watchdog well beyond the expected run
   initial begin
      #50us;
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
